// >>> verilog/owm_regs.svh
// timing constants and field values for the single-wire bus master
`ifndef OWM_REGS_SVH
`define OWM_REGS_SVH
`define OWM_CLK_MHZ 100
`define OWM_TICK_MHZ 1
`define OWM_DIV_DEFAULT 8'h64
`define OWM_DIV_MIN 8'h0a
`define OWM_RESET_LOW_US 511
`define OWM_RESET_RECOVERY_US 512
`define OWM_PRESENCE_SAMPLE_US 68
`define OWM_WRITE_ZERO_LOW_US 100
`define OWM_READ_SLOT_LOW_US 5
`define OWM_READ_SAMPLE_US 13
`define OWM_SLOT_US 117
`endif

// >>> verilog/owm_pkg.sv
// types for the single-wire bus master
package owm_pkg;
  typedef enum logic [1:0] {
    OWM_CMD_WRITE0 = 2'b00,
    OWM_CMD_WRITE1 = 2'b01,
    OWM_CMD_READ = 2'b10
  } owm_cmd_t;
  typedef struct packed {
    logic in;
    logic out;
    logic oe;
  } owm_pin_t;
endpackage : owm_pkg

// >>> verilog/owm_tick_div.sv
// integer divider making the microsecond tick
`timescale 1ns/10ps
module owm_tick_div #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic [WIDTH-1:0] divide,
  // tick
  output logic tick
);
  logic [WIDTH-1:0] count;
  wire logic wrap = (count >= divide - {{(WIDTH-1){1'b0}}, 1'b1}) || (divide == '0);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      tick <= run & wrap;
      if (!run || wrap) count <= '0;
      else count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule : owm_tick_div

// >>> verilog/owm_master.sv
// single-wire bus master: reset/presence and bit slots
//
// Contract
// (R1) reset low at least 480 us, then presence
// (R2) slave waits 15-60 us before presence
// (R3) presence pulse lasts 60-240 us
// (R4) request launches reset, clears on presence
// (R5) sample presence, latch result for software
// (R6) reset 511, recovery 512, sample 68 us
// (R7) write0 low 100, read low 5, sample 13
// (R8) 1 MHz tick from programmable integer divider
// (R9) main clock at least 10 MHz
// (R10) software counts slaves, hardware reports any
// (R11) short low releases; write0 holds full time
// (R12) drive low only, open drain
`include "owm_regs.svh"
`timescale 1ns/10ps
module owm_master
  import owm_pkg::*;
#(
  parameter int DIV_WIDTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic [DIV_WIDTH-1:0] clock_divide,
  input wire logic reset_presence_set,
  output logic reset_presence_request,
  output logic presence_detected,
  // bit slots
  input wire logic slot_valid,
  input wire owm_cmd_t slot_cmd,
  output logic slot_ready,
  output logic read_valid,
  output logic read_bit,
  // line
  input wire logic line_in,
  output logic line_out,
  output logic line_oe
);
  typedef enum logic [2:0] {
    OWM_IDLE = 3'b000,
    OWM_RST_LOW = 3'b001,
    OWM_RST_HIGH = 3'b010,
    OWM_SLOT = 3'b011
  } owm_state_t;

  localparam logic [9:0] T_RESET_LOW_TIME = 10'(`OWM_RESET_LOW_US);
  localparam logic [9:0] T_RESET_RECOVERY_TIME = 10'(`OWM_RESET_RECOVERY_US);
  localparam logic [9:0] T_PST = 10'(`OWM_PRESENCE_SAMPLE_US);
  localparam logic [9:0] T_WRITE_ZERO_LOW_TIME = 10'(`OWM_WRITE_ZERO_LOW_US);
  localparam logic [9:0] T_READ_SLOT_LOW_TIME = 10'(`OWM_READ_SLOT_LOW_US);
  localparam logic [9:0] T_RDS = 10'(`OWM_READ_SAMPLE_US);
  localparam logic [9:0] T_SLOT = 10'(`OWM_SLOT_US);

  // state and timing
  owm_state_t state;
  owm_state_t next_state;
  owm_cmd_t cmd;
  owm_pin_t pin;
  logic [9:0] us;
  logic line_meta;
  logic line_sync;
  logic tick;
  logic drive_low;

  // two-stage synchroniser on the line
  // reset to the idle level so no false presence follows reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end else begin
      line_meta <= line_in;
      line_sync <= line_meta;
    end
  end

  // state decode
  wire logic in_idle = (state == OWM_IDLE);
  wire logic in_rst_low = (state == OWM_RST_LOW);
  wire logic in_rst_high = (state == OWM_RST_HIGH);
  wire logic in_slot = (state == OWM_SLOT);
  wire logic busy = !in_idle;

  // divider idles between sequences so each one starts on a whole tick
  // tick lags run by one cycle: every low phase carries one extra clock
  owm_tick_div #(.WIDTH(DIV_WIDTH)) u_div ( // R8
    .clk(clk),
    .rstn(rstn),
    .run(busy),
    .divide(clock_divide),
    .tick(tick)
  );

  // points on the microsecond count
  wire logic at_reset_low_time_end = (us == T_RESET_LOW_TIME - 10'h001);
  wire logic at_reset_recovery_time_end = (us == T_RESET_RECOVERY_TIME - 10'h001);
  wire logic at_pst = (us == T_PST);
  wire logic at_rds = (us == T_RDS);
  wire logic at_slot_end = (us == T_SLOT - 10'h001);

  // low phase of a slot: write0 long, read and write1 short
  wire logic [9:0] slot_low = (cmd == OWM_CMD_WRITE0) ? T_WRITE_ZERO_LOW_TIME : T_READ_SLOT_LOW_TIME; // R7 R11
  // the tick term holds the line through the last counted microsecond
  wire logic slot_low_hold = (us < slot_low - 10'h001 || !tick) && (us < slot_low); // R11

  // sequence events; a reset request outranks a pending slot
  wire logic start_reset = in_idle && reset_presence_request;
  wire logic start_slot = in_idle && !reset_presence_request && slot_valid;
  wire logic rst_low_done = in_rst_low && tick && at_reset_low_time_end; // R1 R6
  wire logic rst_high_done = in_rst_high && tick && at_reset_recovery_time_end; // R6
  wire logic pst_point = in_rst_high && tick && at_pst; // R5 R6
  wire logic rd_point = in_slot && tick && at_rds &&
    (cmd == OWM_CMD_READ); // R7
  // fixed slot length leaves the slave time to recover
  wire logic slot_done = in_slot && tick && at_slot_end;

  // line low at the sample point means a slave answered
  wire logic presence_seen = pst_point && !pin.in; // R5

  // line driver request
  wire logic drive_reset = start_reset || (in_rst_low && !rst_low_done); // R1
  wire logic drive_slot = start_slot || (in_slot && slot_low_hold); // R11
  wire logic next_drive_low = drive_reset || drive_slot;

  // counter restarts in idle and when the reset low phase ends
  wire logic us_clear = in_idle || rst_low_done;
  wire logic [9:0] next_us = us_clear ? 10'h000 : (tick ? us + 10'h001 : us);
  wire owm_cmd_t next_cmd = start_slot ? slot_cmd : cmd;

  // a fresh set wins over a clear in the same cycle
  wire logic next_request = reset_presence_set || (reset_presence_request && !presence_seen); // R4
  wire logic next_presence = start_reset ? 1'b0 : (pst_point ? !pin.in : presence_detected); // R5 R10
  wire logic next_read_bit = rd_point ? pin.in : read_bit; // R7

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      OWM_IDLE: begin
        if (start_reset) next_state = OWM_RST_LOW; // R1 R4
        else if (start_slot) next_state = OWM_SLOT;
      end
      OWM_RST_LOW: begin
        if (rst_low_done) next_state = OWM_RST_HIGH;
      end
      OWM_RST_HIGH: begin
        // no presence: request stays set and the sequence repeats
        if (rst_high_done) next_state = OWM_IDLE;
      end
      OWM_SLOT: begin
        if (slot_done) next_state = OWM_IDLE;
      end
      default: next_state = OWM_IDLE;
    endcase
  end

  // open-drain pin: only ever pulls low
  assign pin = '{in: line_sync, out: 1'b0, oe: drive_low}; // R12
  assign slot_ready = in_idle && !reset_presence_request;
  assign line_out = pin.out; // R12
  assign line_oe = pin.oe; // R12

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= OWM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // microsecond counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      us <= 10'h000;
    end else begin
      us <= next_us; // R6 R7
    end
  end

  // slot command, held for the whole slot
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd <= OWM_CMD_WRITE1;
    end else begin
      cmd <= next_cmd;
    end
  end

  // line driver, registered so the pin never glitches
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= next_drive_low; // R11 R12
    end
  end

  // request bit and presence latch
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reset_presence_request <= 1'b0;
      presence_detected <= 1'b0;
    end else begin
      reset_presence_request <= next_request; // R4
      presence_detected <= next_presence; // R5
    end
  end

  // read data
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_valid <= 1'b0;
      read_bit <= 1'b0;
    end else begin
      read_valid <= rd_point; // R7
      read_bit <= next_read_bit;
    end
  end
endmodule : owm_master

// >>> testbench/owm_master_props.sv
// port assertions for the single-wire bus master
`timescale 1ns/10ps
module owm_master_props
  import owm_pkg::*;
(
  // clock and control
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_presence_set,
  input wire logic reset_presence_request,
  input wire logic presence_detected,
  // slots and line
  input wire logic slot_valid,
  input wire owm_cmd_t slot_cmd,
  input wire logic slot_ready,
  input wire logic read_valid,
  input wire logic line_out,
  input wire logic line_oe
);
  logic [9:0] low;
  wire take = slot_valid && slot_ready;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) low <= 10'h000;
    else low <= line_oe ? low + 10'h001 : 10'h000;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_line_low_only:
    assert property (line_out == 1'b0) else $error("line high");
  a_low_time_ok:
    assert property ($fell(line_oe) |-> low inside {[5:6], [100:101], [511:512]}) else $error("low");
  a_take_drives_low:
    assert property (take |=> line_oe) else $error("no drive");
  a_read_sample_time:
    assert property (take && slot_cmd == OWM_CMD_READ |-> ##[12:16] read_valid) else $error("read");
  a_write1_short:
    assert property (take && slot_cmd == OWM_CMD_WRITE1 |=> line_oe ##[4:6] !line_oe) else $error("w1");
  a_read_low_short:
    assert property (take && slot_cmd == OWM_CMD_READ |=> line_oe ##[4:6] !line_oe) else $error("rd low");
  a_write0_long:
    assert property (take && slot_cmd == OWM_CMD_WRITE0 |-> ##101 line_oe ##1 !line_oe)
    else $error("w0");
  a_request_set:
    assert property (reset_presence_set |=> reset_presence_request) else $error("set");
  a_request_clear:
    assert property ($fell(reset_presence_request) |-> ##[0:1] presence_detected) else $error("clr");
  a_presence_cleared:
    assert property ($rose(line_oe) && reset_presence_request |-> ##[0:1] !presence_detected)
    else $error("stale");
endmodule : owm_master_props
bind owm_master owm_master_props owm_master_props_i (.*);

// >>> testbench/owm_slave.sv
// behavioural single-wire slave
`timescale 1ns/10ps
module owm_slave (
  // line and behaviour
  input wire logic clk,
  input wire logic line,
  input wire logic present,
  input wire logic data,
  output logic pull
);
  int low = 0;
  int hold = 0;
  assign pull = hold > 0 && hold <= 120;
  always @(posedge clk) begin
    low <= line ? 0 : low + 1;
    if (hold > 0) hold <= hold - 1;
    else if (line && low >= 480 && present) hold <= 150;
    else if (!line && low == 0 && !data) hold <= 30;
  end
endmodule : owm_slave

// >>> testbench/owm_master_tb_top.sv
// bench for the single-wire bus master
`timescale 1ns/10ps
module owm_master_tb_top;
  import owm_pkg::*;
  logic clk = 0, rstn = 0, st = 0, sv = 0, pr = 1, dt = 1;
  logic req, pd, rdy, rv, rb, lo, oe, pl;
  owm_cmd_t cmd = OWM_CMD_WRITE1;
  wire ln = !(oe && !lo || pl);
  int errors = 0, compares = 0;
  logic q[$];
  initial forever #5 clk = ~clk;
  owm_master owm_master_i (.clk(clk), .rstn(rstn), .clock_divide(8'h01), .reset_presence_set(st),
    .reset_presence_request(req), .presence_detected(pd), .slot_valid(sv), .slot_cmd(cmd),
    .slot_ready(rdy), .read_valid(rv), .read_bit(rb), .line_in(ln), .line_out(lo), .line_oe(oe));
  owm_slave owm_slave_i (.clk(clk), .line(ln), .present(pr), .data(dt), .pull(pl));
  task automatic chk(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic till(input bit r, input logic v);
    for (int i = 0; i < 3000 && (r ? rdy : req) !== v; i++) begin
      @(posedge clk);
      #1;
    end
    chk(r ? rdy : req, v);
  endtask : till
  task automatic give_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  always @(posedge clk) if (rv === 1'b1) chk(rb, q.pop_front());
  initial begin
    #300000 errors++;
    give_verdict();
  end
  initial begin
    void'($urandom(57886));
    repeat (20) @(posedge clk);
    #1 rstn = 1;
    // slave present, absent (reset repeats), present again
    for (int k = 0; k < 3; k++) begin
      pr = k != 1;
      st = 1;
      @(posedge clk) #1 st = 0;
      if (k == 1) #25000;
      else till(0, 0);
      chk(pd, pr);
      chk(req, !pr);
    end
    for (int i = 0; i < 16; i++) begin
      till(1, 1);
      cmd = (i < 3) ? owm_cmd_t'(i) : owm_cmd_t'($urandom % 3);
      dt = 1'($urandom);
      if (cmd == OWM_CMD_READ) q.push_back(dt);
      sv = 1;
      @(posedge clk) #1 sv = 0;
    end
    till(1, 1);
    chk(q.size() == 0, 1'b1);
    give_verdict();
  end
endmodule : owm_master_tb_top
